// ### verilog/dbi_pkg.sv
// Package with command codes, timing constants and types for the bank logic.
package dbi_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_RTP_PS      = 7500;
  localparam int T_RP_PS       = 15000;
  localparam int T_RAS_PS      = 45000;
  localparam int T_RC_PS       = 60000;
  localparam int RTP_CYC = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC  = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RC_CYC  = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CCD_CYC = 2;
  localparam int CNT_W   = 6;
  localparam int NBANK   = 4;
  localparam int A10_BIT = 10;

  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] WR_RST = 3'h3;
  localparam logic       BL8_RST = 1'h1;

  typedef enum logic [2:0]
  {
    DBI_NOP,
    DBI_ACT,
    DBI_RD,
    DBI_WR,
    DBI_PRE
  } dbi_cmd_t;

  typedef logic [CNT_W-1:0] dbi_cnt_t;

  // Cycle count from a read command to the earliest internal close.
  function automatic dbi_cnt_t dbi_rd_close(input logic [2:0] al,
                                            input logic       bl8);
    int v;
    v = int'(al) + (bl8 ? 4 : 2);
    v = v + ((RTP_CYC > 2) ? RTP_CYC : 2) - 2;
    return dbi_cnt_t'(v);
  endfunction

  function automatic dbi_cnt_t dbi_wr_close(input logic [2:0] al,
                                            input logic [2:0] cl,
                                            input logic       bl8,
                                            input logic [2:0] wr);
    int v;
    v = int'(al) + int'(cl) - 1 + (bl8 ? 4 : 2) + int'(wr);
    return dbi_cnt_t'(v);
  endfunction

endpackage

// ### verilog/dbi_if.sv
// Interface carrying the command bus between controller and memory.
`timescale 1ns/1ps
interface dbi_if;
  import dbi_pkg::*;
  dbi_cmd_t    cmd;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic        bank_ready;
  logic        illegal;

  modport mem
  (
    input  cmd,
    input  ba,
    input  addr,
    output bank_ready,
    output illegal
  );
  modport ctl
  (
    output cmd,
    output ba,
    output addr,
    input  bank_ready,
    input  illegal
  );
endinterface

// ### verilog/dbi_mem_bank.sv
// Memory end: per-bank state, auto-close scheduling and command checks.
`timescale 1ns/1ps
// What this block does
// - No burst interrupt with burst length four.
// - Eight-beat read interrupted only by read.
// - Eight-beat write interrupted only by write.
// - Read interrupt exactly two cycles later.
// - Write interrupt exactly two cycles later.
// - Interrupt may target any bank.
// - Never interrupt an auto-close burst.
// - Auto-close command may interrupt plain burst.
// - Spacing uses programmed burst length only.
// - Precharge: A10 high all, else one bank.
// - Read to precharge spacing minimum.
// - Respect active time and precharge time.
// - Write to precharge spacing minimum.
// - A10 on column command selects auto-close.
// - Write auto-close waits for write recovery.
// - Auto-close postponed until active time met.
// - Read auto-close at AL plus BL/2.
// - Activate after read auto-close waits longer.
// - Close no earlier than two after prefetch.
// - Read auto-close reopen waits precharge, cycle.
// - Write auto-close reopen waits recovery, cycle.
// - Latencies derive from programmed mode values.
module dbi_mem_bank
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Programmed mode values.
  input  wire logic [2:0] al_in,
  input  wire logic [2:0] cl_in,
  input  wire logic [2:0] wr_in,
  input  wire logic       bl8_in,
  // Command bus.
  dbi_if.mem              bus,
  // Bank status.
  output logic [3:0]      open_out,
  output logic            violation_out
);
  import dbi_pkg::*;

  logic [3:0] open_r;
  logic [3:0] ap_r;
  dbi_cnt_t   ras_r [NBANK];
  dbi_cnt_t   rp_r  [NBANK];
  dbi_cnt_t   rc_r  [NBANK];
  dbi_cnt_t   cls_r [NBANK];
  logic       burst_r;
  logic       burst_wr_r;
  logic       burst_ap_r;
  dbi_cnt_t   burst_cnt_r;
  dbi_cnt_t   blen;
  logic       col_cmd;
  logic       ready_r;
  logic       bad;
  logic [3:0] sel;

  assign blen    = bl8_in ? dbi_cnt_t'(4) : dbi_cnt_t'(2);
  assign col_cmd = (bus.cmd == DBI_RD) || (bus.cmd == DBI_WR);

  // Precharge bank select.
  always_comb
  begin
    sel = 4'h0;
    if (bus.addr[A10_BIT])
      sel = 4'hF;
    else
      sel[bus.ba] = 1'b1;
  end

  // Burst tracker for interrupt legality.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      burst_r     <= 1'b0;
      burst_wr_r  <= 1'b0;
      burst_ap_r  <= 1'b0;
      burst_cnt_r <= '0;
    end
    else if (col_cmd)
    begin
      burst_r     <= 1'b1;
      burst_wr_r  <= (bus.cmd == DBI_WR);
      burst_ap_r  <= bus.addr[A10_BIT];
      burst_cnt_r <= blen - dbi_cnt_t'(2);
    end
    else if (burst_r)
    begin
      if (burst_cnt_r == '0)
        burst_r <= 1'b0;
      else
        burst_cnt_r <= burst_cnt_r - dbi_cnt_t'(1);
    end
  end

  // Command legality against the burst in flight.
  always_comb
  begin
    bad = 1'b0;
    if (burst_r && bus.cmd != DBI_NOP)
    begin
      if (!bl8_in || burst_ap_r)
        bad = 1'b1;
      else if (burst_wr_r ? (bus.cmd != DBI_WR) : (bus.cmd != DBI_RD))
        bad = 1'b1;
      else if (burst_cnt_r != dbi_cnt_t'(blen - CCD_CYC - 1))
        bad = 1'b1;
    end
    for (int i = 0; i < NBANK; i++)
    begin
      if (bus.cmd == DBI_PRE && sel[i] && open_r[i]
          && (ras_r[i] > dbi_cnt_t'(1) || cls_r[i] > dbi_cnt_t'(1)))
        bad = 1'b1;
      if (bus.cmd == DBI_ACT && bus.ba == 2'(i)
          && (open_r[i] || rp_r[i] > dbi_cnt_t'(1)
              || rc_r[i] > dbi_cnt_t'(1)))
        bad = 1'b1;
      if (col_cmd && bus.ba == 2'(i) && (!open_r[i] || ap_r[i]))
        bad = 1'b1;
    end
  end

  // Per-bank state machine and counters.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      open_r <= 4'h0;
      ap_r   <= 4'h0;
      for (int i = 0; i < NBANK; i++)
      begin
        ras_r[i] <= '0;
        rp_r[i]  <= '0;
        rc_r[i]  <= '0;
        cls_r[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NBANK; i++)
      begin
        if (ras_r[i] != '0)
          ras_r[i] <= ras_r[i] - dbi_cnt_t'(1);
        if (rp_r[i] != '0)
          rp_r[i] <= rp_r[i] - dbi_cnt_t'(1);
        if (rc_r[i] != '0)
          rc_r[i] <= rc_r[i] - dbi_cnt_t'(1);
        if (cls_r[i] != '0)
          cls_r[i] <= cls_r[i] - dbi_cnt_t'(1);
        if (ap_r[i] && cls_r[i] <= dbi_cnt_t'(1)
            && ras_r[i] <= dbi_cnt_t'(1))
        begin
          open_r[i] <= 1'b0;
          ap_r[i]   <= 1'b0;
          rp_r[i]   <= dbi_cnt_t'(RP_CYC);
        end
        if (bus.cmd == DBI_ACT && bus.ba == 2'(i))
        begin
          open_r[i] <= 1'b1;
          ras_r[i]  <= dbi_cnt_t'(RAS_CYC);
          rc_r[i]   <= dbi_cnt_t'(RC_CYC);
        end
        else if (bus.cmd == DBI_PRE && sel[i])
        begin
          open_r[i] <= 1'b0;
          ap_r[i]   <= 1'b0;
          rp_r[i]   <= dbi_cnt_t'(RP_CYC);
        end
        else if (bus.cmd == DBI_RD && bus.ba == 2'(i))
        begin
          cls_r[i] <= dbi_rd_close(al_in, bl8_in);
          ap_r[i]  <= bus.addr[A10_BIT];
        end
        else if (bus.cmd == DBI_WR && bus.ba == 2'(i))
        begin
          cls_r[i] <= dbi_wr_close(al_in, cl_in, bl8_in, wr_in);
          ap_r[i]  <= bus.addr[A10_BIT];
        end
      end
    end
  end

  // Registered status outputs.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      open_out      <= 4'h0;
      violation_out <= 1'b0;
      ready_r       <= 1'b0;
    end
    else
    begin
      open_out      <= open_r;
      violation_out <= bad;
      ready_r       <= !burst_r && !col_cmd;
    end
  end

  assign bus.bank_ready = ready_r;
  assign bus.illegal    = violation_out;

endmodule

// ### verilog/dbi_ctl_end.sv
// Controller end: issues one user request with legal spacing.
`timescale 1ns/1ps
module dbi_ctl_end
(
  // Clock and reset.
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  // Programmed mode values.
  input  wire logic [2:0]         al_in,
  input  wire logic [2:0]         cl_in,
  input  wire logic [2:0]         wr_in,
  input  wire logic               bl8_in,
  // User request.
  input  wire logic               req_in,
  input  dbi_pkg::dbi_cmd_t       req_cmd_in,
  input  wire logic [1:0]         req_ba_in,
  input  wire logic [12:0]        req_addr_in,
  output logic                    busy_out,
  // Command bus.
  dbi_if.ctl                      bus
);
  import dbi_pkg::*;

  dbi_cnt_t    wait_r;
  dbi_cmd_t    cmd_r;
  logic [1:0]  ba_r;
  logic [12:0] addr_r;
  dbi_cnt_t    gap;

  // Spacing before the next command may follow this one.
  always_comb
  begin
    unique case (req_cmd_in)
      DBI_ACT: gap = dbi_cnt_t'(RAS_CYC);
      DBI_RD:  gap = dbi_rd_close(al_in, bl8_in) + dbi_cnt_t'(RP_CYC
                 + (bl8_in ? 2 : 0));
      DBI_WR:  gap = dbi_wr_close(al_in, cl_in, bl8_in, wr_in)
                 + dbi_cnt_t'(RP_CYC);
      DBI_PRE: gap = dbi_cnt_t'(RP_CYC);
      default: gap = '0;
    endcase
  end

  // Issue one command, then hold off; bursts are never interrupted.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wait_r <= '0;
      cmd_r  <= DBI_NOP;
      ba_r   <= 2'h0;
      addr_r <= 13'h0;
    end
    else if (wait_r == '0 && req_in && req_cmd_in != DBI_NOP)
    begin
      cmd_r  <= req_cmd_in;
      ba_r   <= req_ba_in;
      addr_r <= req_addr_in;
      wait_r <= gap;
    end
    else
    begin
      cmd_r <= DBI_NOP;
      if (wait_r != '0)
        wait_r <= wait_r - dbi_cnt_t'(1);
    end
  end

  assign busy_out = (wait_r != '0);
  assign bus.cmd  = cmd_r;
  assign bus.ba   = ba_r;
  assign bus.addr = addr_r;

endmodule

// ### sim/dbi_bus_monitor.sv
// Checker of command spacing on the bus between the two ends.
`timescale 1ns/1ps
module dbi_bus_monitor
(
  // Clock and reset.
  input wire logic         clk_in,
  input wire logic         arst_n_in,
  // Command bus.
  input dbi_pkg::dbi_cmd_t cmd,
  input wire logic [1:0]   ba,
  input wire logic [12:0]  addr,
  input wire logic         bank_ready,
  input wire logic         illegal
);
  import dbi_pkg::*;
  // Figures assume AL 0, CL 3, write recovery 3 and a burst of eight.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_legal_accepted : assert property (
    cmd != DBI_NOP |=> !illegal [*2]) else $error("Legal command refused.");
  a_act_hold_pre : assert property (
    cmd == DBI_ACT |=> (cmd != DBI_PRE) [*8]) else $error("Early close.");
  a_pre_hold_act : assert property (
    cmd == DBI_PRE |=> (cmd != DBI_ACT) [*2]) else $error("Early open.");
  a_rd_hold_pre : assert property (
    cmd == DBI_RD |=> (cmd != DBI_PRE) [*3]) else $error("Read to close.");
  a_wr_hold_pre : assert property (
    cmd == DBI_WR |=> (cmd != DBI_PRE) [*8]) else $error("Write to close.");
  a_rdac_reopen : assert property (
    cmd == DBI_RD && addr[A10_BIT] |=> (cmd != DBI_ACT) [*6])
    else $error("Read auto-close reopened early.");
  a_wrac_reopen : assert property (
    cmd == DBI_WR && addr[A10_BIT] |=> (cmd != DBI_ACT) [*8])
    else $error("Write auto-close reopened early.");
  a_burst_not_ready : assert property (
    cmd inside {DBI_RD, DBI_WR} |=> !bank_ready [*4] ##1 bank_ready)
    else $error("Ready flag wrong around a burst.");
  a_no_interrupt : assert property (
    cmd inside {DBI_RD, DBI_WR} |=> !(cmd inside {DBI_RD, DBI_WR}) [*3])
    else $error("Burst interrupted.");
endmodule

// ### sim/ddr2_burst_interrupt_precharge_tb_top.sv
// Bench joining both ends, plus a memory end driven by the bench.
`timescale 1ns/1ps
module ddr2_burst_interrupt_precharge_tb_top;
  import dbi_pkg::*;
  logic        clk_in = 1'h0;
  logic        arst_n_in = 1'h0;
  logic        arst2_n = 1'h0;
  logic [2:0]  al = 3'h0;
  logic [2:0]  cl = 3'h3;
  logic [2:0]  wr = 3'h3;
  logic        bl8 = 1'h1;
  logic        bl8_b = 1'h1;
  logic        req = 1'h0;
  dbi_cmd_t    req_cmd = DBI_NOP;
  logic [1:0]  req_ba = 2'h0;
  logic [12:0] req_addr = 13'h0;
  logic        busy;
  logic [3:0]  open_a;
  logic [3:0]  open_b;
  logic [3:0]  mask;
  logic        viol_a;
  logic        viol_b;
  logic        seen_b = 1'h0;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  // Fault cases: burst length, commands with their A10, gap, outcome.
  logic [8:0]  t_bl8 = 9'h1FB;
  logic [8:0]  t_a1 = 9'h080;
  logic [8:0]  t_a2 = 9'h003;
  logic [8:0]  t_exp = 9'h1FC;
  dbi_cmd_t    t_c1 [9] = '{DBI_RD, DBI_WR, DBI_RD, DBI_RD, DBI_WR,
                            DBI_RD, DBI_WR, DBI_RD, DBI_RD};
  dbi_cmd_t    t_c2 [9] = '{DBI_RD, DBI_WR, DBI_RD, DBI_WR, DBI_RD,
                            DBI_RD, DBI_WR, DBI_RD, DBI_PRE};
  int          t_gap [9] = '{2, 2, 1, 2, 2, 3, 3, 2, 2};
  dbi_if bus_a ();
  dbi_if bus_b ();
  dbi_ctl_end dbi_ctl_end_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .al_in(al), .cl_in(cl), .wr_in(wr), .bl8_in(bl8), .req_in(req),
    .req_cmd_in(req_cmd), .req_ba_in(req_ba), .req_addr_in(req_addr),
    .busy_out(busy), .bus(bus_a));
  dbi_mem_bank dbi_mem_bank_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .al_in(al), .cl_in(cl), .wr_in(wr), .bl8_in(bl8), .bus(bus_a),
    .open_out(open_a), .violation_out(viol_a));
  dbi_mem_bank dbi_mem_bank_b_i (.clk_in(clk_in), .arst_n_in(arst2_n),
    .al_in(al), .cl_in(cl), .wr_in(wr), .bl8_in(bl8_b), .bus(bus_b),
    .open_out(open_b), .violation_out(viol_b));
  dbi_bus_monitor dbi_bus_monitor_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .cmd(bus_a.cmd), .ba(bus_a.ba),
    .addr(bus_a.addr), .bank_ready(bus_a.bank_ready),
    .illegal(bus_a.illegal));
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic issue(input dbi_cmd_t c, input logic [1:0] b,
                       input logic a10);
    for (int n = 0; n < 40 && busy !== 1'h0; n++)
      tick(1);
    req = 1'h1;
    req_cmd = c;
    req_ba = b;
    req_addr = {2'h0, a10, 10'h0};
    tick(1);
    req = 1'h0;
  endtask
  task automatic put(input dbi_cmd_t c, input logic [1:0] b,
                     input logic a10, input int gap);
    bus_b.cmd = c;
    bus_b.ba = b;
    bus_b.addr = {2'h0, a10, 10'h0};
    tick(1);
    bus_b.cmd = DBI_NOP;
    tick(gap - 1);
  endtask
  always @(posedge clk_in)
  begin
    if (arst2_n !== 1'h1)
      seen_b <= 1'h0;
    else if (viol_b === 1'h1)
      seen_b <= 1'h1;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    bus_b.cmd = DBI_NOP;
    bus_b.ba = 2'h0;
    bus_b.addr = 13'h0;
    tick(20);
    arst_n_in = 1'h1;
    arst2_n = 1'h1;
    check(open_a, 4'h0);
    check(bus_a.cmd, DBI_NOP);
    mask = 4'hF;
    for (int b = 0; b < 4; b++)
      issue(DBI_ACT, 2'(b), 1'h0);
    tick(3);
    check(open_a, mask);
    for (int b = 0; b < 4; b++)
    begin
      issue(DBI_PRE, 2'(b), 1'h0);
      tick(3);
      mask[b] = 1'h0;
      check(open_a, mask);
    end
    issue(DBI_ACT, 2'h0, 1'h0);
    issue(DBI_ACT, 2'h3, 1'h0);
    issue(DBI_PRE, 2'h2, 1'h1);
    tick(3);
    check(open_a, 4'h0);
    $display("Test precharge done");
    issue(DBI_ACT, 2'h1, 1'h0);
    issue(DBI_ACT, 2'h2, 1'h0);
    issue(DBI_RD, 2'h1, 1'h0);
    issue(DBI_RD, 2'h2, 1'h1);
    tick(3);
    check(open_a, 4'h6);
    tick(10);
    check(open_a, 4'h2);
    issue(DBI_WR, 2'h1, 1'h1);
    tick(6);
    check(open_a, 4'h2);
    tick(10);
    check(open_a, 4'h0);
    $display("Test auto-close done");
    for (int k = 0; k < 9; k++)
    begin
      arst2_n = 1'h0;
      bl8_b = t_bl8[k];
      tick(1);
      arst2_n = 1'h1;
      put(DBI_ACT, 2'h0, 1'h0, 2);
      put(DBI_ACT, 2'h1, 1'h0, 12);
      put(t_c1[k], 2'h0, t_a1[k], t_gap[k]);
      put(t_c2[k], 2'h1, t_a2[k], 4);
      check(seen_b, t_exp[k]);
    end
    $display("Test interrupt cases done");
    arst2_n = 1'h0;
    tick(1);
    arst2_n = 1'h1;
    put(DBI_ACT, 2'h2, 1'h0, 2);
    put(DBI_RD, 2'h2, 1'h1, 6);
    check(open_b, 4'h4);
    tick(12);
    check(open_b, 4'h0);
    $display("Test active time hold done");
    al = 3'h2;
    put(DBI_ACT, 2'h1, 1'h0, 12);
    put(DBI_RD, 2'h1, 1'h1, 6);
    check(open_b, 4'h2);
    tick(2);
    check(open_b, 4'h0);
    check(seen_b, 1'h0);
    put(DBI_ACT, 2'h1, 1'h0, 4);
    check(seen_b, 1'h1);
    $display("Test added latency done");
    end_sim();
  end
endmodule
